//--- rtl/pie_defs.svh
// constants for the partial instruction execute block
`ifndef PIE_DEFS_SVH
`define PIE_DEFS_SVH
`define PIE_PC_W 13
`define PIE_TGT_W 11
`define PIE_ADDR_W 7
`define PIE_LATCH_HI 4
`define PIE_LATCH_LO 3
`define PIE_ZERO_BYTE 8'h00
`define PIE_ONE_BYTE 8'h01
`define PIE_DEST_ACC 1'b0
`define PIE_DEST_FILE 1'b1
`endif

//--- rtl/pie_pkg.sv
// types for the partial instruction execute block
package pie_pkg;
  typedef enum logic [2:0] {
    PIE_OP_NONE = 3'h0,
    PIE_OP_CALL = 3'h1,
    PIE_OP_WDT_CLEAR = 3'h2,
    PIE_OP_FILE_CLEAR = 3'h3,
    PIE_OP_FILE_INVERT = 3'h4,
    PIE_OP_FILE_DEC = 3'h5,
    PIE_OP_ACC_CLEAR = 3'h6
  } pie_op_e;
  typedef enum logic [1:0] {
    PIE_ST_IDLE = 2'b00,
    PIE_ST_CALL2 = 2'b01
  } pie_state_e;
endpackage : pie_pkg

//--- rtl/pie_alu.sv
// byte operations with zero detect
`timescale 1ns/1ps
module pie_alu #(
  parameter int WIDTH = 8
) (
  // operand and selection
  input wire logic [WIDTH-1:0] i_operand,
  input wire logic i_dec,
  // result
  output logic [WIDTH-1:0] o_result,
  output logic o_zero
);
  always_comb begin
    if (i_dec) begin
      o_result = i_operand - WIDTH'(1);
    end else begin
      o_result = ~i_operand;
    end
    o_zero = (o_result == '0);
  end
endmodule : pie_alu

//--- rtl/pie_core.sv
// execution of call, watchdog clear, clear, complement and decrement
// Function
// RL1: call loads 11-bit target into pc low
// RL2: call pushes pc plus one first
// RL3: pc bits 12:11 from latch bits 4:3
// RL4: call takes two cycles, flags unchanged
// RL5: watchdog clear zeroes counter and prescaler
// RL6: watchdog clear sets timeout and powerdown flags
// RL7: file clear writes zero, sets zero flag
// RL8: complement inverts file register, updates zero
// RL9: destination bit 0 accumulator, 1 file
// RL10: decrement subtracts one, updates zero, stores
// RL11: accumulator clear loads zero, sets zero
// RL12: zero flag equals result is zero
`timescale 1ns/1ps
`include "pie_defs.svh"
module pie_core import pie_pkg::*; (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // instruction
  input wire logic i_valid,
  input wire pie_op_e i_op,
  input wire logic [`PIE_TGT_W-1:0] i_target,
  input wire logic [`PIE_ADDR_W-1:0] i_faddr,
  input wire logic i_dest,
  // core state in
  input wire logic [`PIE_PC_W-1:0] i_pc,
  input wire logic [7:0] i_pc_upper_latch,
  input wire logic [7:0] i_fdata,
  // handshake
  output logic o_ready,
  // program counter and stack
  output logic o_pc_load,
  output logic [`PIE_PC_W-1:0] o_pc,
  output logic o_stack_push,
  output logic [`PIE_PC_W-1:0] o_stack_top,
  // file write
  output logic o_fwrite,
  output logic [`PIE_ADDR_W-1:0] o_fwaddr,
  output logic [7:0] o_fwdata,
  // accumulator
  output logic o_acc_write,
  output logic [7:0] o_acc,
  // status
  output logic o_zero_write,
  output logic o_zero_flag,
  output logic o_watchdog_counter_clr,
  output logic o_prescaler_clr,
  output logic o_timeout_flag_set,
  output logic o_powerdown_flag_set
);
  pie_state_e state_r, state_nxt;
  logic [`PIE_PC_W-1:0] pc_r, pc_nxt, tos_r, tos_nxt;
  logic pc_load_r, pc_load_nxt, push_r, push_nxt;
  logic fwrite_r, fwrite_nxt, accw_r, accw_nxt, zw_r, zw_nxt, z_r, z_nxt;
  logic [`PIE_ADDR_W-1:0] fwaddr_r, fwaddr_nxt;
  logic [7:0] fwdata_r, fwdata_nxt, acc_r, acc_nxt;
  logic wdt_r, wdt_nxt;
  logic [7:0] alu_res;
  logic alu_zero;
  logic take;

  pie_alu #(.WIDTH(8)) u_alu (
    .i_operand(i_fdata),
    .i_dec(i_op == PIE_OP_FILE_DEC),
    .o_result(alu_res),
    .o_zero(alu_zero)
  );

  assign o_ready = (state_r == PIE_ST_IDLE);
  assign take = i_valid && o_ready;

  always_comb begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    tos_nxt = tos_r;
    fwaddr_nxt = fwaddr_r;
    fwdata_nxt = fwdata_r;
    acc_nxt = acc_r;
    z_nxt = z_r;
    pc_load_nxt = 1'b0;
    push_nxt = 1'b0;
    fwrite_nxt = 1'b0;
    accw_nxt = 1'b0;
    zw_nxt = 1'b0;
    wdt_nxt = 1'b0;
    case (state_r)
      PIE_ST_IDLE: begin
        if (take) begin
          case (i_op)
            PIE_OP_CALL: begin
              tos_nxt = i_pc + `PIE_PC_W'(1); // RL2
              push_nxt = 1'b1; // RL2
              pc_nxt = {i_pc_upper_latch[`PIE_LATCH_HI:`PIE_LATCH_LO], i_target}; // RL1 RL3
              state_nxt = PIE_ST_CALL2; // RL4
            end
            PIE_OP_WDT_CLEAR: begin
              wdt_nxt = 1'b1; // RL5 RL6
            end
            PIE_OP_FILE_CLEAR: begin
              fwaddr_nxt = i_faddr;
              fwdata_nxt = `PIE_ZERO_BYTE; // RL7
              fwrite_nxt = 1'b1;
              z_nxt = 1'b1; // RL7
              zw_nxt = 1'b1;
            end
            PIE_OP_FILE_INVERT, PIE_OP_FILE_DEC: begin
              z_nxt = alu_zero; // RL8 RL10 RL12
              zw_nxt = 1'b1;
              if (i_dest == `PIE_DEST_FILE) begin
                fwaddr_nxt = i_faddr; // RL9
                fwdata_nxt = alu_res;
                fwrite_nxt = 1'b1;
              end else begin
                acc_nxt = alu_res; // RL9
                accw_nxt = 1'b1;
              end
            end
            PIE_OP_ACC_CLEAR: begin
              acc_nxt = `PIE_ZERO_BYTE; // RL11
              accw_nxt = 1'b1;
              z_nxt = 1'b1; // RL11
              zw_nxt = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
      PIE_ST_CALL2: begin
        pc_load_nxt = 1'b1; // RL4
        state_nxt = PIE_ST_IDLE;
      end
      default: begin
        state_nxt = PIE_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_r <= PIE_ST_IDLE;
      pc_r <= '0;
      tos_r <= '0;
      fwaddr_r <= '0;
      fwdata_r <= '0;
      acc_r <= '0;
      z_r <= 1'b0;
      pc_load_r <= 1'b0;
      push_r <= 1'b0;
      fwrite_r <= 1'b0;
      accw_r <= 1'b0;
      zw_r <= 1'b0;
      wdt_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      tos_r <= tos_nxt;
      fwaddr_r <= fwaddr_nxt;
      fwdata_r <= fwdata_nxt;
      acc_r <= acc_nxt;
      z_r <= z_nxt;
      pc_load_r <= pc_load_nxt;
      push_r <= push_nxt;
      fwrite_r <= fwrite_nxt;
      accw_r <= accw_nxt;
      zw_r <= zw_nxt;
      wdt_r <= wdt_nxt;
    end
  end

  assign o_pc_load = pc_load_r;
  assign o_pc = pc_r;
  assign o_stack_push = push_r;
  assign o_stack_top = tos_r;
  assign o_fwrite = fwrite_r;
  assign o_fwaddr = fwaddr_r;
  assign o_fwdata = fwdata_r;
  assign o_acc_write = accw_r;
  assign o_acc = acc_r;
  assign o_zero_write = zw_r;
  assign o_zero_flag = z_r;
  assign o_watchdog_counter_clr = wdt_r;
  assign o_prescaler_clr = wdt_r;
  assign o_timeout_flag_set = wdt_r;
  assign o_powerdown_flag_set = wdt_r;

  sequence s_call_take;
    take && i_op == PIE_OP_CALL;
  endsequence
  sequence s_push_then_load;
    o_stack_push && !o_pc_load ##1 o_pc_load && !o_stack_push;
  endsequence

  chk_call_target: assert property (@(posedge i_mclk) disable iff (i_rst) // RL1
    s_call_take |-> ##2 o_pc[`PIE_TGT_W-1:0] == $past(i_target, 2))
    else $error("call target not loaded");
  chk_call_push: assert property (@(posedge i_mclk) disable iff (i_rst) // RL2
    s_call_take |-> ##1 s_push_then_load)
    else $error("push does not precede pc load");
  chk_ret_addr: assert property (@(posedge i_mclk) disable iff (i_rst) // RL2
    s_call_take |=> o_stack_top == $past(i_pc) + 13'h0001)
    else $error("return address wrong");
  chk_upper_bits: assert property (@(posedge i_mclk) disable iff (i_rst) // RL3
    s_call_take |-> ##2 o_pc[12:11] == $past(i_pc_upper_latch[4:3], 2))
    else $error("upper pc bits wrong");
  chk_call_flags: assert property (@(posedge i_mclk) disable iff (i_rst) // RL4
    s_call_take |=> !o_ready && !o_zero_write && !o_timeout_flag_set
      ##1 o_ready && !o_zero_write && !o_timeout_flag_set)
    else $error("call timing or flags wrong");
  chk_wdt_clear: assert property (@(posedge i_mclk) disable iff (i_rst) // RL5
    take && i_op == PIE_OP_WDT_CLEAR |=> o_watchdog_counter_clr && o_prescaler_clr)
    else $error("watchdog not cleared");
  chk_wdt_flags: assert property (@(posedge i_mclk) disable iff (i_rst) // RL6
    take && i_op == PIE_OP_WDT_CLEAR |=> o_timeout_flag_set && o_powerdown_flag_set
      && !o_zero_write)
    else $error("status flags not set");
  chk_file_clear: assert property (@(posedge i_mclk) disable iff (i_rst) // RL7
    take && i_op == PIE_OP_FILE_CLEAR |=> o_fwrite && o_fwdata == 8'h00 && o_zero_flag
      && o_fwaddr == $past(i_faddr))
    else $error("file clear wrong");
  chk_invert: assert property (@(posedge i_mclk) disable iff (i_rst) // RL8
    take && i_op == PIE_OP_FILE_INVERT && i_dest |=> o_fwdata == ~$past(i_fdata))
    else $error("complement wrong");
  chk_dest_acc: assert property (@(posedge i_mclk) disable iff (i_rst) // RL9
    take && (i_op == PIE_OP_FILE_INVERT || i_op == PIE_OP_FILE_DEC) && !i_dest
      |=> o_acc_write && !o_fwrite)
    else $error("destination select wrong");
  chk_decrement: assert property (@(posedge i_mclk) disable iff (i_rst) // RL10
    take && i_op == PIE_OP_FILE_DEC && !i_dest |=> o_acc == $past(i_fdata) - 8'h01)
    else $error("decrement wrong");
  chk_acc_clear: assert property (@(posedge i_mclk) disable iff (i_rst) // RL11
    take && i_op == PIE_OP_ACC_CLEAR |=> o_acc_write && o_acc == 8'h00 && o_zero_flag)
    else $error("accumulator clear wrong");
  chk_zero_flag: assert property (@(posedge i_mclk) disable iff (i_rst) // RL12
    o_zero_write && (o_fwrite || o_acc_write) |->
      o_zero_flag == ((o_fwrite ? o_fwdata : o_acc) == 8'h00))
    else $error("zero flag mismatch");
endmodule : pie_core

//--- sim/partial_instruction_execute_tb_top.sv
// self-checking bench for the partial instruction execute core
`timescale 1ns/1ps
`include "pie_defs.svh"
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("CHECK FAILED %s exp=%0h got=%0h", nm, exp, got); end end
module partial_instruction_execute_tb_top import pie_pkg::*;;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_valid = 1'b0;
  pie_op_e i_op = PIE_OP_NONE;
  logic [10:0] i_target = 11'h000;
  logic [6:0] i_faddr = 7'h00;
  logic i_dest = 1'b0;
  logic [12:0] i_pc = 13'h0000;
  logic [7:0] i_pc_upper_latch = 8'h00;
  logic [7:0] i_fdata = 8'h00;
  logic o_ready, o_pc_load, o_stack_push, o_fwrite, o_acc_write, o_zero_write, o_zero_flag;
  logic o_watchdog_counter_clr, o_prescaler_clr, o_timeout_flag_set, o_powerdown_flag_set;
  logic [12:0] o_pc, o_stack_top;
  logic [6:0] o_fwaddr;
  logic [7:0] o_fwdata, o_acc;
  int n_errors = 0;
  int num_checks = 0;
  int unsigned seed_v;
  logic [7:0] m_acc = 8'h00;
  logic [7:0] m_fd = 8'h00;
  logic [6:0] m_fa = 7'h00;
  logic m_z = 1'b0;
  logic [12:0] m_pc = 13'h0000;
  logic [12:0] m_tos = 13'h0000;

  always #10 i_mclk = ~i_mclk;

  pie_core uut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_valid(i_valid), .i_op(i_op), .i_target(i_target),
    .i_faddr(i_faddr), .i_dest(i_dest), .i_pc(i_pc), .i_pc_upper_latch(i_pc_upper_latch),
    .i_fdata(i_fdata), .o_ready(o_ready), .o_pc_load(o_pc_load), .o_pc(o_pc),
    .o_stack_push(o_stack_push), .o_stack_top(o_stack_top), .o_fwrite(o_fwrite),
    .o_fwaddr(o_fwaddr), .o_fwdata(o_fwdata), .o_acc_write(o_acc_write), .o_acc(o_acc),
    .o_zero_write(o_zero_write), .o_zero_flag(o_zero_flag),
    .o_watchdog_counter_clr(o_watchdog_counter_clr), .o_prescaler_clr(o_prescaler_clr),
    .o_timeout_flag_set(o_timeout_flag_set), .o_powerdown_flag_set(o_powerdown_flag_set)
  );

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  // one instruction through the core, model computed alongside
  task automatic run_op(input pie_op_e op, input logic [10:0] tgt, input logic [6:0] fa,
                        input logic d, input logic [12:0] pc, input logic [7:0] lat,
                        input logic [7:0] fd);
    logic [7:0] p_exp;
    logic [7:0] r;
    logic [7:0] got_p;
    @(posedge i_mclk);
    i_valid <= 1'b1;
    i_op <= op;
    i_target <= tgt;
    i_faddr <= fa;
    i_dest <= d;
    i_pc <= pc;
    i_pc_upper_latch <= lat;
    i_fdata <= fd;
    @(posedge i_mclk);
    i_valid <= (op == PIE_OP_CALL);
    i_op <= (op == PIE_OP_CALL) ? PIE_OP_ACC_CLEAR : op;
    #1;
    r = 8'h00;
    case (op)
      PIE_OP_CALL: begin
        p_exp = 8'h80;
        m_tos = pc + 13'h0001;
        m_pc = {lat[4:3], tgt};
      end
      PIE_OP_WDT_CLEAR: p_exp = 8'h0F;
      PIE_OP_FILE_CLEAR: begin
        p_exp = 8'h50;
        m_fa = fa;
        m_fd = 8'h00;
        m_z = 1'b1;
      end
      PIE_OP_FILE_INVERT, PIE_OP_FILE_DEC: begin
        r = (op == PIE_OP_FILE_DEC) ? fd - 8'h01 : ~fd;
        p_exp = d ? 8'h50 : 8'h30;
        m_z = (r == 8'h00);
        if (d) begin
          m_fa = fa;
          m_fd = r;
        end else begin
          m_acc = r;
        end
      end
      PIE_OP_ACC_CLEAR: begin
        p_exp = 8'h30;
        m_acc = 8'h00;
        m_z = 1'b1;
      end
      default: p_exp = 8'h00;
    endcase
    got_p = {o_stack_push, o_fwrite, o_acc_write, o_zero_write,
      o_watchdog_counter_clr, o_prescaler_clr, o_timeout_flag_set, o_powerdown_flag_set};
    `CHK("pulses", p_exp, got_p)
    `CHK("acc_model", m_acc, o_acc)
    `CHK("fwdata_model", m_fd, o_fwdata)
    `CHK("fwaddr_model", m_fa, o_fwaddr)
    `CHK("zero_model", m_z, o_zero_flag)
    `CHK("pc_model", m_pc, o_pc)
    `CHK("tos_model", m_tos, o_stack_top)
    if (op == PIE_OP_CALL) begin
      `CHK("stack_top", pc + 13'h0001, o_stack_top)
      `CHK("pc", {lat[4:3], tgt}, o_pc)
      `CHK("ready", 1'b0, o_ready)
      @(posedge i_mclk);
      i_valid <= 1'b0;
      #1;
      `CHK("pc_load", 1'b1, o_pc_load)
      `CHK("refused", 1'b0, o_acc_write)
      `CHK("ready", 1'b1, o_ready)
    end else begin
      `CHK("pc_load", 1'b0, o_pc_load)
    end
    if (p_exp[6]) begin
      `CHK("fwaddr", fa, o_fwaddr)
      `CHK("fwdata", r, o_fwdata)
    end
    if (p_exp[5]) begin
      `CHK("acc", r, o_acc)
    end
    if (p_exp[4]) begin
      `CHK("zero", (r == 8'h00), o_zero_flag)
    end
    $display("test op %0d done", op);
  endtask : run_op

  initial begin
    seed_v = $urandom(32'h9113);
    repeat (12) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    #1;
    `CHK("ready", 1'b1, o_ready)
    run_op(PIE_OP_FILE_DEC, 11'h000, 7'h7F, 1'b1, 13'h0000, 8'h00, 8'h01);
    run_op(PIE_OP_FILE_DEC, 11'h000, 7'h00, 1'b0, 13'h0000, 8'h00, 8'h00);
    run_op(PIE_OP_FILE_INVERT, 11'h000, 7'h11, 1'b0, 13'h0000, 8'h00, 8'hFF);
    run_op(PIE_OP_CALL, 11'h7FF, 7'h00, 1'b0, 13'h1FFF, 8'h18, 8'h00);
    run_op(PIE_OP_NONE, 11'h000, 7'h00, 1'b0, 13'h0000, 8'h00, 8'h00);
    // mid-run reset, model back to reset values
    @(posedge i_mclk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    m_acc = 8'h00;
    m_fd = 8'h00;
    m_fa = 7'h00;
    m_z = 1'b0;
    m_pc = 13'h0000;
    m_tos = 13'h0000;
    @(posedge i_mclk);
    #1;
    `CHK("ready", 1'b1, o_ready)
    $display("test mid-run reset done");
    for (int i = 0; i < 80; i++) begin
      run_op(pie_op_e'(3'($urandom_range(6, 1))), 11'($urandom), 7'($urandom), 1'($urandom),
             13'($urandom), 8'($urandom), 8'($urandom));
    end
    finish_test();
  end

  initial begin
    #20000;
    n_errors++;
    finish_test();
  end
endmodule : partial_instruction_execute_tb_top
